// *** hw/msc_cfg.svh ***
// Purpose: constants for the maintenance scan controls
// Assumes: included by bare name
// Notes: offsets, codes and counts only
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH
// ********************
// register map
// ********************
`define MSC_ADDR_CTRL 4'h0
`define MSC_ADDR_STAT 4'h1
`define MSC_ADDR_OP 4'h2
`define MSC_ADDR_SDR 4'h3
`define MSC_ADDR_SEQ 4'h4
`define MSC_ADDR_MICROSTORE_ADDRESS_REG 4'h5
`define MSC_ADDR_LOGCNT 4'h6
// ********************
// field positions
// ********************
`define MSC_SDR_STORAGE_ENABLE_OVERRIDE_BIT 4
`define MSC_SDR_CHAIN_BIT 5
`define MSC_SDR_SUP_BIT 6
`define MSC_SDR_MICROSTORE_ADDRESS_REG_HI 12
`define MSC_SDR_MICROSTORE_ADDRESS_REG_LO 1
`define MSC_FOLD_SRC_HI 3
`define MSC_FOLD_DST_LO 4
`define MSC_OP_FOLD_BIT 7
// ********************
// codes and counts
// ********************
`define MSC_EMIT_LOAD 4'h8
`define MSC_EMIT_PF_SET 4'h1
`define MSC_EMIT_PF_CLR 4'h5
`define MSC_EMIT_BT_SET 4'h2
`define MSC_EMIT_BT_CLR 4'h3
`define MSC_EMIT_BT_TEST 4'h4
`define MSC_OP_BT_CLR_A 8'h07
`define MSC_OP_BT_CLR_B 8'h08
`define MSC_OP_BT_TEST 8'h0e
`define MSC_OP_BT_STEP 8'h0f
`define MSC_OP_FOLD_A 8'h31
`define MSC_OP_FOLD_B 8'h35
`define MSC_OP_FOLD_C 8'h36
`define MSC_OP_FOLD_D 8'h37
`define MSC_SEQ_LIMIT 3'h7
`define MSC_REPEAT_RESET 4'h1
`define MSC_LOG_MAX_WORDS 6'h2a
`define MSC_ENTRY_FETCH_LINK 12'hf4e
`define MSC_ENTRY_EXEC_LINK 12'hf8b
`define MSC_LINK_FETCH_HEX 16'h1e9c
`define MSC_LINK_EXEC_HEX 16'h1f16
`endif

// *** hw/msc_pkg.sv ***
// Purpose: types of the maintenance scan controls
// Assumes: nothing
// Notes: modes are one-hot
package msc_pkg;
  typedef enum logic [2:0] {
    MSC_MODE_SEQ = 3'h1,
    MSC_MODE_MS = 3'h2,
    MSC_MODE_ROS = 3'h4
  } msc_mode_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } msc_bus_s;
  typedef struct packed {
    logic scan_ctl;
    logic [3:0] emit;
    logic test_chain;
    logic repeat_step;
    logic exec_link;
    logic error;
    logic logout_pb;
    logic start_pb;
    logic force_pass_sw;
    logic diag_load;
    logic [31:0] reg_in;
  } msc_uop_s;
endpackage

// *** hw/msc_sync2.sv ***
// Purpose: two-stage synchroniser for panel pins
// Assumes: level inputs
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module msc_sync2
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [2:0] d_in,
  output logic [2:0] q_out
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end
    else
    begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end
  assign q_out = s2_q;
endmodule
`default_nettype wire

// *** hw/msc_logseq.sv ***
// Purpose: logout mode walk and word counter
// Assumes: start is a one-cycle pulse
// Notes: seq, main store, microstore in turn
`timescale 1ns/1ps
`default_nettype none
`include "msc_cfg.svh"
module msc_logseq
  import msc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic word_in,
  output msc_mode_e mode_out,
  output logic busy_out,
  output logic [5:0] count_out
);
  typedef struct packed {
    msc_mode_e mode;
    logic busy;
    logic [5:0] cnt;
  } msc_ls_s;
  msc_ls_s s_q;
  msc_ls_s s_d;
  always_comb
  begin
    s_d = s_q;
    if (start_in && !s_q.busy)
    begin
      s_d.busy = 1'b1;
      s_d.mode = MSC_MODE_SEQ;
      s_d.cnt = 6'h0;
    end
    else if (s_q.busy && word_in)
    begin
      // never more than the allowed logout words
      if (s_q.cnt != `MSC_LOG_MAX_WORDS)
        s_d.cnt = s_q.cnt + 6'h1;
      case (s_q.mode)
        MSC_MODE_SEQ: s_d.mode = MSC_MODE_MS;
        MSC_MODE_MS: s_d.mode = MSC_MODE_ROS;
        MSC_MODE_ROS:
        begin
          s_d.busy = 1'b0;
        end
        default: s_d.mode = MSC_MODE_ROS;
      endcase
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      s_q <= '{mode: MSC_MODE_ROS, busy: 1'b0, cnt: 6'h0};
    else
      s_q <= s_d;
  end
  assign mode_out = s_q.mode;
  assign busy_out = s_q.busy;
  assign count_out = s_q.cnt;
  chk_log_cap: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_q.cnt <= `MSC_LOG_MAX_WORDS) else $error("logout word count over cap");
endmodule
`default_nettype wire

// *** hw/msc_top.sv ***
// Purpose: maintenance scan and fault-test controls
// Assumes: micro-orders come from the sequencer on clk_in
// Notes: panel pins synchronised; registers on a plain port
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "msc_cfg.svh"
module msc_top
  import msc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire msc_bus_s bus_in,
  output logic [31:0] rdata_out,
  input wire msc_uop_s uop_in,
  input wire logic log_request_in,
  input wire logic logout_pb_pin_in,
  input wire logic start_pb_pin_in,
  input wire logic force_pass_pin_in,
  output logic [31:0] scan_bus_out,
  output logic inhibit_storage_out,
  output logic seq_control_out,
  output logic log_ind_out,
  output logic branch_pass_out,
  output logic branch_fail_out,
  output logic branch_chain_out,
  output logic branch_bt_out,
  output logic branch_repeat_out,
  output logic [11:0] microstore_address_reg_out,
  output logic [11:0] entry_fetch_out,
  output logic [11:0] entry_exec_out,
  output logic [3:0] clock_stop_out,
  output logic [2:0] mode_out
);
  // ********************
  // state
  // ********************
  typedef struct packed {
    logic sup;
    logic storage_enable_override;
    logic chain;
    logic bt;
    logic pass;
    logic fail;
    logic logt;
    logic [3:0] rpt;
    logic [2:0] seq;
    logic [7:0] op;
    logic [31:0] storage_data_reg;
    logic [11:0] microstore_address_reg;
    logic [3:0] stop;
    logic [31:0] scan;
    logic [31:0] rdata;
    logic pb_q;
    logic st_q;
    logic bt_hit;
  } msc_st_s;
  msc_st_s s_q;
  msc_st_s s_d;
  logic [2:0] pins;
  msc_mode_e lmode;
  logic lbusy;
  logic [5:0] lcnt;
  logic inhibit;
  logic seq_done;
  logic emit_load;
  logic logout_go;
  msc_sync2 u_sync
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .d_in({logout_pb_pin_in, start_pb_pin_in, force_pass_pin_in}),
    .q_out(pins)
  );
  msc_logseq u_log
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .start_in(logout_go),
    .word_in(bus_in.wr && bus_in.addr == `MSC_ADDR_LOGCNT),
    .mode_out(lmode),
    .busy_out(lbusy),
    .count_out(lcnt)
  );
  function automatic logic is_fold(input logic [7:0] op);
    logic [7:0] c;
    c = {1'b0, op[6:0]};
    is_fold = op[`MSC_OP_FOLD_BIT] && (c == `MSC_OP_FOLD_A || c == `MSC_OP_FOLD_B ||
      c == `MSC_OP_FOLD_C || c == `MSC_OP_FOLD_D);
  endfunction
  // ********************
  // next state
  // ********************
  assign inhibit = s_q.sup && !s_q.storage_enable_override;
  assign seq_done = s_q.sup && s_q.seq == `MSC_SEQ_LIMIT;
  assign emit_load = uop_in.scan_ctl && uop_in.emit == `MSC_EMIT_LOAD;
  // pushbutton edge from the second sync stage only
  assign logout_go = (pins[2] && !s_q.pb_q) || (uop_in.error && log_request_in);
  always_comb
  begin
    s_d = s_q;
    s_d.pb_q = pins[2];
    s_d.st_q = pins[1];
    s_d.bt_hit = 1'b0;
    if (bus_in.wr)
    begin
      case (bus_in.addr)
        `MSC_ADDR_OP: s_d.op = bus_in.wdata[7:0];
        `MSC_ADDR_SDR: s_d.storage_data_reg = bus_in.wdata;
        `MSC_ADDR_SEQ: s_d.seq = bus_in.wdata[2:0];
        `MSC_ADDR_CTRL: s_d.stop = bus_in.wdata[3:0];
        default: s_d.op = s_q.op;
      endcase
    end
    if (s_q.sup && !seq_done)
      s_d.seq = s_q.seq + 3'h1;
    // test clear first so a set source in the same cycle wins
    if (uop_in.test_chain && !inhibit)
      s_d.chain = 1'b0;
    if (emit_load)
    begin
      s_d.sup = s_q.storage_data_reg[`MSC_SDR_SUP_BIT];
      s_d.storage_enable_override = s_q.storage_data_reg[`MSC_SDR_STORAGE_ENABLE_OVERRIDE_BIT];
      s_d.chain = s_q.storage_data_reg[`MSC_SDR_CHAIN_BIT];
    end
    if (seq_done)
    begin
      s_d.sup = 1'b0;
      s_d.storage_enable_override = 1'b0;
    end
    if (uop_in.diag_load || (pins[1] && !s_q.st_q && pins[0]))
      s_d.chain = 1'b1;
    if (lbusy || s_q.logt)
      s_d.chain = 1'b0;
    if (logout_go)
      s_d.logt = 1'b1;
    else if (!lbusy && lmode == MSC_MODE_ROS && s_q.logt && !pins[2])
      s_d.logt = 1'b0;
    if (lmode == MSC_MODE_MS && bus_in.wr && bus_in.addr == `MSC_ADDR_OP)
    begin
      case (bus_in.wdata[7:0])
        `MSC_OP_BT_CLR_A, `MSC_OP_BT_CLR_B: s_d.bt = 1'b0;
        `MSC_OP_BT_STEP: s_d.bt = !s_q.bt;
        `MSC_OP_BT_TEST: s_d.bt_hit = s_q.bt;
        default: s_d.bt = s_q.bt;
      endcase
    end
    if (lmode == MSC_MODE_ROS && uop_in.scan_ctl)
    begin
      case (uop_in.emit)
        `MSC_EMIT_BT_SET: s_d.bt = 1'b1;
        `MSC_EMIT_BT_CLR: s_d.bt = 1'b0;
        `MSC_EMIT_BT_TEST: s_d.bt_hit = s_q.bt;
        `MSC_EMIT_PF_SET:
        begin
          s_d.fail = s_q.fail | s_q.bt;
          s_d.pass = s_q.pass | !s_q.bt;
        end
        `MSC_EMIT_PF_CLR:
        begin
          s_d.fail = 1'b0;
          s_d.pass = 1'b0;
        end
        default: s_d.bt_hit = 1'b0;
      endcase
    end
    if (uop_in.repeat_step)
      s_d.rpt = s_q.rpt + 4'h1;
    if (uop_in.exec_link)
      s_d.microstore_address_reg = s_q.storage_data_reg[`MSC_SDR_MICROSTORE_ADDRESS_REG_HI:`MSC_SDR_MICROSTORE_ADDRESS_REG_LO];
    s_d.scan = uop_in.reg_in;
    if (is_fold(s_q.op))
    begin
      s_d.scan = s_q.storage_data_reg;
      s_d.scan[`MSC_FOLD_DST_LO +: 4] = uop_in.reg_in[`MSC_FOLD_SRC_HI -: 4];
    end
    s_d.rdata = 32'h0;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        `MSC_ADDR_CTRL: s_d.rdata = {28'h0, s_q.stop};
        `MSC_ADDR_STAT: s_d.rdata = {18'h0, s_q.rpt, s_q.seq, s_q.bt, s_q.pass,
          s_q.fail, s_q.logt, s_q.chain, s_q.storage_enable_override, s_q.sup};
        `MSC_ADDR_OP: s_d.rdata = {24'h0, s_q.op};
        `MSC_ADDR_SDR: s_d.rdata = s_q.storage_data_reg;
        `MSC_ADDR_SEQ: s_d.rdata = {29'h0, s_q.seq};
        `MSC_ADDR_MICROSTORE_ADDRESS_REG: s_d.rdata = {20'h0, s_q.microstore_address_reg};
        `MSC_ADDR_LOGCNT: s_d.rdata = {26'h0, lcnt};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      s_q <= '0;
      s_q.rpt <= `MSC_REPEAT_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  // ********************
  // outputs
  // ********************
  // bit numbering is ascending-left in the machine, so fold moves low nibbles here
  assign rdata_out = s_q.rdata;
  assign scan_bus_out = s_q.scan;
  assign inhibit_storage_out = inhibit;
  assign seq_control_out = s_q.sup;
  assign log_ind_out = s_q.logt;
  assign branch_pass_out = s_q.pass;
  assign branch_fail_out = s_q.fail;
  assign branch_chain_out = s_q.chain;
  assign branch_bt_out = s_q.bt_hit;
  assign branch_repeat_out = s_q.rpt == 4'h0;
  assign microstore_address_reg_out = s_q.microstore_address_reg;
  assign entry_fetch_out = `MSC_ENTRY_FETCH_LINK;
  assign entry_exec_out = `MSC_ENTRY_EXEC_LINK;
  assign clock_stop_out = s_q.stop;
  assign mode_out = lmode;
  // ********************
  // checks
  // ********************
  sequence load_pulse;
    emit_load && !seq_done && !uop_in.diag_load;
  endsequence
  chk_sup_load: assert property (@(posedge clk_in) disable iff (!rst_b_in) load_pulse |=>
    s_q.sup == $past(s_q.storage_data_reg[6])) else $error("sequence-limit flag not loaded");
  chk_sup_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) seq_done |=>
    !s_q.sup) else $error("sequence-limit flag not cleared at seven");
  chk_storage_enable_override_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) seq_done |=>
    !s_q.storage_enable_override) else $error("override flag not cleared");
  chk_inhibit_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    emit_load && !seq_done && s_q.storage_data_reg[6] && !s_q.storage_data_reg[4] |=> inhibit_storage_out)
    else $error("storage inhibit wrong");
  chk_chain_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    uop_in.test_chain && inhibit && !emit_load && !uop_in.diag_load && !lbusy && !s_q.logt
    && !(pins[1] && !s_q.st_q) |=> s_q.chain == $past(s_q.chain)) else $error("chained flag lost");
  chk_chain_log: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    lbusy |=> !s_q.chain) else $error("chained flag on during logout");
  chk_log_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    uop_in.error && log_request_in |=> log_ind_out) else $error("log trigger not set");
  chk_pf_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    lmode == MSC_MODE_ROS && uop_in.scan_ctl && uop_in.emit == 4'h5 |=> !s_q.pass && !s_q.fail)
    else $error("pass fail not cleared");
  chk_fail_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    lmode == MSC_MODE_ROS && uop_in.scan_ctl && uop_in.emit == 4'h1 && s_q.bt |=> s_q.fail)
    else $error("fail not set");
endmodule
`default_nettype wire

// *** verification/msc_seq_model.sv ***
// Purpose: sequencer and panel model facing the scan controls
// Assumes: tasks are entered just after a rising edge
// Notes: data lines go to the inverse between orders
`timescale 1ns/1ps
`default_nettype none
module msc_seq_model
  import msc_pkg::*;
(
  input wire logic clk_in,
  output msc_uop_s uop_out,
  output logic log_request_out,
  output logic logout_pin_out,
  output logic start_pin_out,
  output logic force_pass_out
);
  // ********************
  // idle levels
  // ********************
  initial
  begin
    uop_out = '0;
    log_request_out = 1'b0;
    logout_pin_out = 1'b0;
    start_pin_out = 1'b0;
    force_pass_out = 1'b0;
  end
  // ********************
  // micro-orders and panel
  // ********************
  // quiet cycle after each order so nothing moves twice in one step
  task automatic issue(input msc_uop_s u);
    msc_uop_s idle;
    idle = '0;
    idle.reg_in = ~u.reg_in;
    uop_out <= u;
    @(posedge clk_in);
    uop_out <= idle;
    @(posedge clk_in);
  endtask
  task automatic req(input logic v);
    log_request_out <= v;
    @(posedge clk_in);
  endtask
  // held long enough to cross the two-flop synchroniser
  task automatic press(input logic start);
    force_pass_out <= start;
    @(posedge clk_in);
    if (start)
    begin
      start_pin_out <= 1'b1;
    end
    else
    begin
      logout_pin_out <= 1'b1;
    end
    repeat (4) @(posedge clk_in);
    start_pin_out <= 1'b0;
    logout_pin_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** verification/msc_top_tb.sv ***
// Purpose: self-checking bench for the scan controls
// Assumes: 100 MHz clock, sync active-low reset
// Notes: expectations come from small integer models
`timescale 1ns/1ps
`default_nettype none
`include "msc_cfg.svh"
module msc_top_tb
  import msc_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  msc_bus_s bus = '0;
  msc_uop_s uop;
  logic [31:0] rdata, scan_bus, storage_data_reg, d, rng;
  logic log_req, lpin, spin, fpin, inhibit, seqc, logind;
  logic bpass, bfail, bchain, bbt, brep;
  logic [11:0] microstore_address_reg, efetch, eexec;
  logic [3:0] cstop;
  logic [2:0] mode;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  int i, n, rep_m;
  msc_top uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus), .rdata_out(rdata), .uop_in(uop),
    .log_request_in(log_req), .logout_pb_pin_in(lpin), .start_pb_pin_in(spin), .force_pass_pin_in(fpin),
    .scan_bus_out(scan_bus), .inhibit_storage_out(inhibit), .seq_control_out(seqc), .log_ind_out(logind),
    .branch_pass_out(bpass), .branch_fail_out(bfail), .branch_chain_out(bchain), .branch_bt_out(bbt),
    .branch_repeat_out(brep), .microstore_address_reg_out(microstore_address_reg), .entry_fetch_out(efetch), .entry_exec_out(eexec),
    .clock_stop_out(cstop), .mode_out(mode));
  msc_seq_model seq (.clk_in(clk_in), .uop_out(uop), .log_request_out(log_req), .logout_pin_out(lpin),
    .start_pin_out(spin), .force_pass_out(fpin));
  // ********************
  // clock, watchdog, helpers
  // ********************
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic end_sim();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic do_reset();
    rst_b_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus <= '0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus <= '0;
    #1 v = rdata;
    @(posedge clk_in);
  endtask
  // kind 0 scan control, 1 chain test, 2 repeat step, 3 linkage, 4 error, 5 data only, 6 diagnose load
  task automatic fire(input int kind, input logic [3:0] e);
    msc_uop_s u;
    u = '0;
    rng = xs(rng);
    u.reg_in = rng;
    u.emit = e;
    u.scan_ctl = (kind == 0);
    u.test_chain = (kind == 1);
    u.repeat_step = (kind == 2);
    u.exec_link = (kind == 3);
    u.error = (kind == 4);
    u.diag_load = (kind == 6);
    seq.issue(u);
  endtask
  task automatic wait_seq_off();
    n = 0;
    while (seqc !== 1'b0 && n < 30)
    begin
      @(posedge clk_in);
      n++;
    end
  endtask
  // ********************
  // main sequence
  // ********************
  initial
  begin
    rng = 32'ha9c6;
    do_reset();
    chk(mode, 3'h4);
    rd(4'h1, d);
    chk(d, 32'h400);
    chk(efetch, 12'hf4e);
    chk(eexec, 12'hf8b);
    rd(4'hf, d);
    chk(d, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      fire(0, i ? 4'h2 : 4'h3);
      fire(0, 4'h5);
      chk({bpass, bfail}, 2'b00);
      fire(0, 4'h1);
      chk({bpass, bfail}, i ? 2'b01 : 2'b10);
      fire(0, 4'h4);
      chk(bbt, i);
    end
    rep_m = 1;
    repeat (15)
    begin
      fire(2, 4'h0);
      rep_m = (rep_m + 1) % 16;
    end
    chk(brep, rep_m == 0);
    fire(2, 4'h0);
    chk(brep, 1'b0);
    // fold only with the select bit and one of the four codes
    rng = xs(rng);
    storage_data_reg = rng;
    wr(4'h3, storage_data_reg);
    wr(4'h0, storage_data_reg);
    chk(cstop, storage_data_reg[3:0]);
    wr(4'h2, 32'hb6);
    fire(5, 4'h0);
    chk(scan_bus, {storage_data_reg[31:8], rng[3:0], storage_data_reg[3:0]});
    wr(4'h2, 32'h36);
    fire(5, 4'h0);
    chk(scan_bus, rng);
    wr(4'h2, 32'hb2);
    fire(5, 4'h0);
    chk(scan_bus, rng);
    // bits 31:29 and 2:0 cleared; the counter is still zero from reset, so the limit is reached within seven steps
    rng = xs(rng);
    storage_data_reg = rng & 32'h1ffffff8;
    storage_data_reg[`MSC_SDR_SUP_BIT] = 1'b1;
    storage_data_reg[`MSC_SDR_STORAGE_ENABLE_OVERRIDE_BIT] = 1'b0;
    storage_data_reg[`MSC_SDR_CHAIN_BIT] = 1'b1;
    wr(4'h3, storage_data_reg);
    fire(0, 4'h8);
    chk({seqc, inhibit, bchain}, 3'b111);
    fire(1, 4'h0);
    chk(bchain, 1'b1);
    fire(3, 4'h0);
    chk(microstore_address_reg, storage_data_reg[12:1]);
    wait_seq_off();
    chk({seqc, inhibit}, 2'b00);
    fire(1, 4'h0);
    chk(bchain, 1'b0);
    fire(6, 4'h0);
    chk(bchain, 1'b1);
    storage_data_reg[`MSC_SDR_STORAGE_ENABLE_OVERRIDE_BIT] = 1'b1;
    wr(4'h3, storage_data_reg);
    // counter is left at seven by the first run
    wr(4'h4, 32'h0);
    fire(0, 4'h8);
    rd(4'h1, d);
    chk({d[1], inhibit}, 2'b10);
    wait_seq_off();
    rd(4'h1, d);
    chk(d[1:0], 2'b00);
    fire(1, 4'h0);
    seq.press(1'b1);
    chk(bchain, 1'b1);
    fire(1, 4'h0);
    seq.req(1'b1);
    fire(4, 4'h0);
    chk(logind, 1'b1);
    wr(4'h3, 32'h1 << `MSC_SDR_CHAIN_BIT);
    fire(0, 4'h8);
    chk(bchain, 1'b0);
    chk(mode, 3'h1);
    wr(4'h6, 32'h0);
    chk(mode, 3'h2);
    wr(4'h2, 32'h07);
    rd(4'h1, d);
    chk(d[6], 1'b0);
    wr(4'h2, 32'h0f);
    wr(4'h2, 32'h0e);
    chk(bbt, 1'b1);
    wr(4'h2, 32'h08);
    rd(4'h1, d);
    chk(d[6], 1'b0);
    wr(4'h6, 32'h0);
    chk(mode, 3'h4);
    wr(4'h6, 32'h0);
    rd(4'h6, d);
    chk(d, 32'h3);
    seq.req(1'b0);
    // second reset in mid-run
    do_reset();
    chk({logind, bchain}, 2'b00);
    rd(4'h1, d);
    chk(d, 32'h400);
    seq.press(1'b0);
    chk(logind, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
